// file: hdl/cplp_pkg.sv
// Purpose: shared constants and types for the coprocessor latch port
// Assumes: one 10 MHz clock; host strobes are asynchronous pins
// Notes:   no software-visible registers; flags are ports
package cplp_pkg;
    localparam int          DATA_W         = 16;
    localparam int          BYTE_W         = 8;
    localparam int          PORT_ADDR_W    = 3;
    localparam int          NUM_GP_PORTS   = 6;
    localparam logic [2:0]  PORT_FIVE_ADDRESS = 3'h5;
    localparam logic [2:0]  PORT_ZERO_ADDRESS = 3'h0;
    localparam int          CLEAR_FLAG_BIT = 0;
    localparam logic [15:0] DATA_RESET     = 16'h0000;
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          INSTR_CYCLES_TO_CLEAR = 4;
    // one instruction cycle taken as one system clock
    localparam int          CLEAR_GAP_CYC  = INSTR_CYCLES_TO_CLEAR;
    localparam logic [2:0]  GAP_ONE        = 3'h1;
    localparam logic [2:0]  GAP_ZERO       = 3'h0;

    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic byte_select;
    } cplp_strobe_t;

    typedef struct packed {
        logic                 rd;
        logic                 wr;
        logic [2:0]           addr;
        logic [DATA_W-1:0]    wdata;
    } cplp_cpu_req_t;

    typedef enum logic [0:0] {
        CPLP_MODE_COPROC,
        CPLP_MODE_MICRO
    } cplp_mode_t;
endpackage

// file: hdl/cplp_sync.sv
// Purpose: two-stage synchroniser for a packed strobe group
// Assumes: inputs asynchronous to clk_sys_i
// Notes:   first stage read only by the second stage
module cplp_sync
    import cplp_pkg::*;
(
    input  wire logic          clk_sys_i,
    input  wire logic          rst_b_i,
    input  wire cplp_strobe_t  async_i,
    output cplp_strobe_t       sync_o
);
    cplp_strobe_t stage1;

    // strobes idle high, so reset to inactive
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            stage1 <= '{rd_n: 1'b1, wr_n: 1'b1, byte_select: 1'b0};
            sync_o <= '{rd_n: 1'b1, wr_n: 1'b1, byte_select: 1'b0};
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

// file: hdl/cplp_edge.sv
// Purpose: rising-edge detector with delayed level
// Assumes: input already synchronised
// Notes:   pulse lasts one clock
module cplp_edge (
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    input  wire logic level_i,
    output logic      rise_o
);
    logic level_d;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            level_d <= 1'b1;
        end else begin
            level_d <= level_i;
        end
    end

    assign rise_o = level_i && !level_d;
endmodule

// file: hdl/cplp_top.sv
// Purpose: latched parallel coprocessor port between a host and the core
// Assumes: host strobes asynchronous; core side synchronous to clk_sys_i
// Notes:   receive/transmit latches, status pins, interrupt and empty flag
//          mode pins and width select are static straps, and the read data
//          path follows the live read strobe, so neither is synchronised;
//          changing them in the middle of a transfer is not supported
// Summary of operation
// [R1] core reaches the latch only as port 5: read receive, write transmit
// [R2] both mode pins tied equal by the board: low coprocessor, high micro
// [R3] microcomputer mode: data lines serve six parallel 16-bit ports instead
// [R4] coprocessor mode latched; width select one gives 16-bit, zero 8-bit
// [R5] host exchange is asynchronous, strobes and status pins only
// [R6] board drives nothing on the interrupt and empty-flag pins
// [R7] only byte-select-low transfers touch interrupt or empty flag
// [R8] interrupt held until port read; flag clear waits four cycles after read
// [R9] core read clears the receive latch; later reads return zero
// [R10] host data lines float except while read strobe low, then transmit data
// [R11] 16-bit host keeps byte select low on every transfer
// [R12] host write strobe low raises receive latch status
// [R13] 16-bit: all sixteen lines captured when write strobe rises
// [R14] after capture the receive interrupt is raised, setting the flag
// [R15] core read clears latch, drops receive status, withdraws interrupt
// [R16] host read strobe low raises transmit status; data driven until high
// [R17] after host read empty flag drops; core write lowers status, raises flag
// [R18] 8-bit width uses only the low eight host data lines; code still drives the high eight low during host reads
// [R19] 8-bit host sends high byte first, then low byte
// [R20] high-byte write latches low lines into receive bits 15..8
// [R21] low-byte write raises status, latches bits 7..0, then interrupts
// [R22] 8-bit read: high byte with select high, low byte with select low
// [R23] writing one to bit 0 at port 0 clears the interrupt flag
// [R24] host strobes pass a two-flop synchroniser before updating flags
module cplp_top
    import cplp_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_b_i,
    // mode pins
    input  wire logic              program_mode_pin_i,
    input  wire logic              microcomputer_mode_pin_i,
    input  wire logic              port_width_select_i,
    // host side
    input  wire logic              host_rd_n_i,
    input  wire logic              host_wr_n_i,
    input  wire logic              byte_select_i,
    input  wire logic [DATA_W-1:0] host_data_lines_i,
    output logic [DATA_W-1:0]      host_data_lines_o,
    output logic                   host_data_lines_oe_o,
    output logic                   rx_latch_status_o,
    output logic                   tx_latch_status_o,
    // core side
    input  wire cplp_cpu_req_t     cpu_req_i,
    output logic [DATA_W-1:0]      cpu_rdata_o,
    output logic                   rx_interrupt_request_o,
    output logic                   rx_interrupt_flag_o,
    output logic                   tx_empty_branch_flag_o,
    // microcomputer mode general ports
    output logic [DATA_W-1:0]      gp_port_data_o,
    output logic [PORT_ADDR_W-1:0] gp_port_addr_o,
    output logic                   gp_port_wr_o,
    output logic                   coproc_mode_o
);
    // --------------------------------------------------------------
    // mode and strobe conditioning
    // --------------------------------------------------------------
    cplp_strobe_t strobe_async;
    cplp_strobe_t strobe_sync;
    logic         coproc_mode;
    logic         wr_rise;
    logic         rd_rise;
    logic         rd_active;
    logic [DATA_W-1:0] rx_latch;
    logic [DATA_W-1:0] tx_latch;
    logic         cpu_rd_p5;
    logic         cpu_wr_p5;
    logic         cpu_wr_p0;
    logic [2:0]   gap_cnt;
    logic         rx_pending;
    logic         lo_sel;
    logic [DATA_W-1:0] data_meta;
    logic [DATA_W-1:0] data_sync;
    logic         lo_wr_rise;
    logic         lo_rd_rise;
    logic         rx_status_set;
    logic         tx_status_set;

    assign strobe_async = '{rd_n: host_rd_n_i, wr_n: host_wr_n_i,
                            byte_select: byte_select_i};

    // [R2] pins assumed equal; either low selects coprocessor
    assign coproc_mode   = !(program_mode_pin_i && microcomputer_mode_pin_i);
    assign coproc_mode_o = coproc_mode;

    // [R24] two-flop synchroniser
    cplp_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .async_i   (strobe_async),
        .sync_o    (strobe_sync)
    );

    cplp_edge u_wr_edge (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .level_i   (strobe_sync.wr_n),
        .rise_o    (wr_rise)
    );

    cplp_edge u_rd_edge (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .level_i   (strobe_sync.rd_n),
        .rise_o    (rd_rise)
    );

    // [R11] [R19] host keeps select low in 16-bit mode
    assign lo_sel    = !strobe_sync.byte_select || port_width_select_i;
    assign rd_active = coproc_mode && !host_rd_n_i;

    // [R7] only low-lane transfers reach status, interrupt and empty flag
    assign lo_wr_rise    = coproc_mode && wr_rise && lo_sel;
    assign lo_rd_rise    = coproc_mode && rd_rise && lo_sel;
    assign rx_status_set = coproc_mode && !strobe_sync.wr_n && lo_sel;
    assign tx_status_set = coproc_mode && !strobe_sync.rd_n && lo_sel;

    // --------------------------------------------------------------
    // host data synchroniser
    // --------------------------------------------------------------
    // [R24] data stays steady around the strobe, so the strobe edge is the
    // handshake and a per-bit two-flop stage cannot tear a word
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            data_meta <= DATA_RESET;
            data_sync <= DATA_RESET;
        end else begin
            data_meta <= host_data_lines_i;
            data_sync <= data_meta;
        end
    end

    // --------------------------------------------------------------
    // core port decode
    // --------------------------------------------------------------
    // one address compare shared by the port five and port zero decodes
    function automatic logic port_hit(input cplp_cpu_req_t req,
                                      input logic [2:0]    addr);
        return req.addr == addr;
    endfunction

    // [R1] only port five reaches the latch
    assign cpu_rd_p5 = coproc_mode && cpu_req_i.rd && port_hit(cpu_req_i, PORT_FIVE_ADDRESS);
    assign cpu_wr_p5 = coproc_mode && cpu_req_i.wr && port_hit(cpu_req_i, PORT_FIVE_ADDRESS);
    assign cpu_wr_p0 = cpu_req_i.wr && port_hit(cpu_req_i, PORT_ZERO_ADDRESS);

    // --------------------------------------------------------------
    // receive latch
    // --------------------------------------------------------------
    // data taken from the synchronised lines at the strobe edge; the host
    // must hold data a few clocks past its strobe for a clean capture
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rx_latch <= DATA_RESET;
        end else if (coproc_mode && wr_rise) begin
            if (port_width_select_i) begin
                // [R13] full word capture
                rx_latch <= data_sync;
            end else if (strobe_sync.byte_select) begin
                // [R20] high byte from low lines
                rx_latch[DATA_W-1:BYTE_W] <= data_sync[BYTE_W-1:0];
            end else begin
                // [R18] [R21] low byte from low lines
                rx_latch[BYTE_W-1:0] <= data_sync[BYTE_W-1:0];
            end
        end else if (cpu_rd_p5) begin
            // [R9] read empties the latch
            rx_latch <= DATA_RESET;
        end
    end

    // --------------------------------------------------------------
    // receive status and interrupt
    // --------------------------------------------------------------
    // [R12] [R15] status high on write strobe low, low after core read
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rx_latch_status_o <= 1'b0;
        end else if (rx_status_set) begin
            rx_latch_status_o <= 1'b1;
        end else if (cpu_rd_p5) begin
            rx_latch_status_o <= 1'b0;
        end
    end

    // [R14] [R7] interrupt after low-byte capture; [R15] read withdraws it
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rx_pending <= 1'b0;
        end else if (lo_wr_rise) begin
            rx_pending <= 1'b1;
        end else if (cpu_rd_p5) begin
            rx_pending <= 1'b0;
        end
    end
    assign rx_interrupt_request_o = rx_pending;

    // [R8] gap counter from read to earliest clear
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            gap_cnt <= GAP_ZERO;
        end else if (cpu_rd_p5) begin
            gap_cnt <= 3'(CLEAR_GAP_CYC);
        end else if (gap_cnt != GAP_ZERO) begin
            gap_cnt <= gap_cnt - GAP_ONE;
        end
    end

    // [R23] [R8] clear only after read and gap; set wins over clear
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rx_interrupt_flag_o <= 1'b0;
        end else if (lo_wr_rise) begin
            rx_interrupt_flag_o <= 1'b1;
        end else if (cpu_wr_p0 && cpu_req_i.wdata[CLEAR_FLAG_BIT]
                     && !rx_pending && gap_cnt == GAP_ZERO) begin
            rx_interrupt_flag_o <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // transmit latch, status and empty flag
    // --------------------------------------------------------------
    // [R1] core output to port five loads transmit latch
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            tx_latch <= DATA_RESET;
        end else if (cpu_wr_p5) begin
            tx_latch <= cpu_req_i.wdata;
        end
    end

    // [R16] [R22] [R17] status high on low-select read, low on core write;
    // a read in flight wins so the host never misses its own access
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            tx_latch_status_o <= 1'b0;
        end else if (tx_status_set) begin
            tx_latch_status_o <= 1'b1;
        end else if (cpu_wr_p5) begin
            tx_latch_status_o <= 1'b0;
        end
    end

    // [R17] [R7] flag low after low-byte read ends; core write restores
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            tx_empty_branch_flag_o <= 1'b1;
        end else if (lo_rd_rise) begin
            tx_empty_branch_flag_o <= 1'b0;
        end else if (cpu_wr_p5) begin
            tx_empty_branch_flag_o <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // host data drive
    // --------------------------------------------------------------
    // [R10] [R5] drive only while read strobe low; combinational so the
    // asynchronous host sees data without waiting on the clock
    always_comb begin
        host_data_lines_oe_o = rd_active;
        host_data_lines_o    = DATA_RESET;
        if (rd_active) begin
            if (port_width_select_i) begin
                // [R4] full word
                host_data_lines_o = tx_latch;
            end else if (byte_select_i) begin
                // [R22] high byte on low lines
                host_data_lines_o[BYTE_W-1:0] = tx_latch[DATA_W-1:BYTE_W];
            end else begin
                // [R18] low byte on low lines
                host_data_lines_o[BYTE_W-1:0] = tx_latch[BYTE_W-1:0];
            end
        end
    end

    // --------------------------------------------------------------
    // core read data and microcomputer-mode ports
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            cpu_rdata_o <= DATA_RESET;
        end else if (cpu_rd_p5) begin
            cpu_rdata_o <= rx_latch;
        end
    end

    // [R3] microcomputer mode: writes go to the general ports
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            gp_port_wr_o <= 1'b0;
        end else begin
            gp_port_wr_o <= !coproc_mode && cpu_req_i.wr
                            && (cpu_req_i.addr < 3'(NUM_GP_PORTS));
        end
    end

    // data and address change on every microcomputer-mode write, strobed or not
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            gp_port_data_o <= DATA_RESET;
            gp_port_addr_o <= PORT_ZERO_ADDRESS;
        end else if (!coproc_mode && cpu_req_i.wr) begin
            gp_port_data_o <= cpu_req_i.wdata;
            gp_port_addr_o <= cpu_req_i.addr;
        end
    end
endmodule

// file: dv/cplp_properties.sv
// Purpose: concurrent checks on the coprocessor latch port pins
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only top-level ports; bound below
module cplp_properties
    import cplp_pkg::*;
(
    input wire logic          clk_sys_i,
    input wire logic          rst_b_i,
    input wire logic          program_mode_pin_i,
    input wire logic          microcomputer_mode_pin_i,
    input wire logic          port_width_select_i,
    input wire logic          host_rd_n_i,
    input wire logic          host_wr_n_i,
    input wire logic          byte_select_i,
    input wire logic          host_data_lines_oe_o,
    input wire logic          rx_latch_status_o,
    input wire logic          tx_latch_status_o,
    input wire cplp_cpu_req_t cpu_req_i,
    input wire logic          rx_interrupt_request_o,
    input wire logic          rx_interrupt_flag_o,
    input wire logic          tx_empty_branch_flag_o,
    input wire logic          coproc_mode_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    logic       low_xfer;
    logic       rd5;
    logic [2:0] gap;
    assign low_xfer = coproc_mode_o && (!byte_select_i || port_width_select_i);
    assign rd5 = coproc_mode_o && cpu_req_i.rd && cpu_req_i.addr == PORT_FIVE_ADDRESS;
    // cycles since last port read; saturates so it never wraps into the window
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            gap <= 3'h7;
        end else if (rd5) begin
            gap <= 3'h0;
        end else if (gap != 3'h7) begin
            gap <= gap + 3'h1;
        end
    end
    a_oe_read_only: assert property (
        host_data_lines_oe_o == (coproc_mode_o && !host_rd_n_i))
        else $error("data lines driven outside a host read");
    a_mode_decode: assert property (
        coproc_mode_o == !(program_mode_pin_i && microcomputer_mode_pin_i))
        else $error("mode decode wrong");
    a_rx_status_set: assert property (
        low_xfer && $fell(host_wr_n_i) |-> ##[2:4] rx_latch_status_o)
        else $error("receive status not raised");
    a_irq_on_capture: assert property (
        low_xfer && $rose(host_wr_n_i) |-> ##[2:4] rx_interrupt_request_o && rx_interrupt_flag_o)
        else $error("no interrupt after capture");
    a_upper_no_irq: assert property (
        coproc_mode_o && byte_select_i && !port_width_select_i && $rose(host_wr_n_i)
        |=> $stable(rx_interrupt_request_o) [*5])
        else $error("upper byte touched interrupt");
    a_read_clears: assert property (
        rd5 |=> !rx_latch_status_o && !rx_interrupt_request_o)
        else $error("port read left status up");
    a_flag_holds: assert property (
        rx_interrupt_request_o |=> rx_interrupt_flag_o)
        else $error("flag cleared while pending");
    a_early_clear: assert property (
        cpu_req_i.wr && cpu_req_i.addr == PORT_ZERO_ADDRESS && cpu_req_i.wdata[0]
        && gap < 3'h4 && rx_interrupt_flag_o |=> rx_interrupt_flag_o)
        else $error("flag cleared too soon after read");
    // a host read still in the synchroniser wins over the core write
    a_tx_reload: assert property (
        coproc_mode_o && cpu_req_i.wr && cpu_req_i.addr == PORT_FIVE_ADDRESS
        && $past(host_rd_n_i, 2) && $past(host_rd_n_i, 3)
        |=> !tx_latch_status_o && tx_empty_branch_flag_o)
        else $error("port write did not refill transmit");
    a_empty_drop: assert property (
        coproc_mode_o && !byte_select_i && $rose(host_rd_n_i) |-> ##[2:4] !tx_empty_branch_flag_o)
        else $error("empty flag not dropped");
    c_host_write: cover property (low_xfer && $rose(host_wr_n_i));
    c_port_read: cover property (rd5);
    c_host_read: cover property (coproc_mode_o && $rose(host_rd_n_i));
endmodule

bind cplp_top cplp_properties u_props (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .program_mode_pin_i(program_mode_pin_i),
    .microcomputer_mode_pin_i(microcomputer_mode_pin_i),
    .port_width_select_i(port_width_select_i), .host_rd_n_i(host_rd_n_i),
    .host_wr_n_i(host_wr_n_i), .byte_select_i(byte_select_i),
    .host_data_lines_oe_o(host_data_lines_oe_o), .rx_latch_status_o(rx_latch_status_o),
    .tx_latch_status_o(tx_latch_status_o), .cpu_req_i(cpu_req_i),
    .rx_interrupt_request_o(rx_interrupt_request_o), .rx_interrupt_flag_o(rx_interrupt_flag_o),
    .tx_empty_branch_flag_o(tx_empty_branch_flag_o), .coproc_mode_o(coproc_mode_o)
);

// file: dv/cplp_host_model.sv
// Purpose: external host driving the asynchronous strobes and data
// Assumes: pins change just after a clock edge
// Notes:   released data lines show the inverse of the last value
module cplp_host_model (
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] rdata_i,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic             sel_o,
    output logic [15:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // flag pins are left undriven: model has no connection to them
    initial begin
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        sel_o = 1'b0;
        data_o = 16'h0000;
    end
    // one strobe cycle: select and data settle before the strobe
    task automatic xfer(input logic is_wr, input logic sel, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge clk_sys_i);
        sel_o <= sel;
        data_o <= d;
        @(posedge clk_sys_i);
        wr_n_o <= !is_wr;
        rd_n_o <= is_wr;
        repeat (5) @(posedge clk_sys_i);
        q = rdata_i;
        wr_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        // data held past the rise: capture lags behind the synchroniser
        repeat (5) @(posedge clk_sys_i);
        data_o <= ~d;
        @(negedge clk_sys_i);
    endtask
endmodule

// file: dv/cplp_top_bench.sv
// Purpose: self-checking bench for the coprocessor latch port
// Assumes: host side played by cplp_host_model
// Notes:   table rows run 16- and 8-bit round trips
module cplp_top_bench
    import cplp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic wide; logic [15:0] word;} cplp_row_t;
    cplp_row_t rows [5] = '{'{1'b1, 16'hA5C3}, '{1'b1, 16'hFFFF}, '{1'b1, 16'h0001},
                            '{1'b0, 16'h1234}, '{1'b0, 16'h80FE}};
    logic          clk_sys_i = 1'b0;
    logic          rst_b_i = 1'b0;
    logic          pm, mc, pws, rd_n, wr_n, sel, oe, rxs, txs, irq, flag, empty, gpw, cmode;
    logic [15:0]   hdata, hout, rdata, gpd;
    logic [2:0]    gpa;
    cplp_cpu_req_t req;
    int            n_mismatch = 0;
    int            n_compared = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    cplp_top dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .program_mode_pin_i(pm),
        .microcomputer_mode_pin_i(mc), .port_width_select_i(pws), .host_rd_n_i(rd_n),
        .host_wr_n_i(wr_n), .byte_select_i(sel), .host_data_lines_i(hdata),
        .host_data_lines_o(hout), .host_data_lines_oe_o(oe), .rx_latch_status_o(rxs),
        .tx_latch_status_o(txs), .cpu_req_i(req), .cpu_rdata_o(rdata),
        .rx_interrupt_request_o(irq), .rx_interrupt_flag_o(flag),
        .tx_empty_branch_flag_o(empty), .gp_port_data_o(gpd), .gp_port_addr_o(gpa),
        .gp_port_wr_o(gpw), .coproc_mode_o(cmode)
    );
    cplp_host_model host (
        .clk_sys_i(clk_sys_i), .rdata_i(hout), .rd_n_o(rd_n), .wr_n_o(wr_n),
        .sel_o(sel), .data_o(hdata)
    );
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic core(input logic rd, input logic wr, input logic [2:0] a,
                        input logic [15:0] d);
        @(posedge clk_sys_i);
        req <= '{rd: rd, wr: wr, addr: a, wdata: d};
        @(posedge clk_sys_i);
        req <= '0;
        @(negedge clk_sys_i);
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_mismatch++;
        $display("MISMATCH t=%0t run hung", $time);
        print_verdict();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] q;
        logic [15:0] tw;
        pm = 1'b0;
        mc = 1'b0;
        pws = 1'b1;
        req = '0;
        repeat (20) @(posedge clk_sys_i);
        chk(16'({rxs, txs, irq, flag, empty, oe}), 16'h0002);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        foreach (rows[i]) begin
            tw = ~rows[i].word;
            @(posedge clk_sys_i);
            pws <= rows[i].wide;
            if (!rows[i].wide) begin
                host.xfer(1'b1, 1'b1, {8'hC3, rows[i].word[15:8]}, q);
                chk(16'({irq, rxs}), 16'h0000);
            end
            host.xfer(1'b1, 1'b0, rows[i].wide ? rows[i].word : {tw[15:8], rows[i].word[7:0]}, q);
            chk(16'({rxs, irq, flag}), 16'h0007);
            core(1'b1, 1'b0, PORT_FIVE_ADDRESS, 16'h0000);
            chk(rdata, rows[i].word);
            chk(16'({rxs, irq}), 16'h0000);
            core(1'b1, 1'b0, PORT_FIVE_ADDRESS, 16'h0000);
            chk(rdata, 16'h0000);
            repeat (4) @(posedge clk_sys_i);
            core(1'b0, 1'b1, PORT_ZERO_ADDRESS, 16'h0001);
            chk(16'(flag), 16'h0000);
            core(1'b0, 1'b1, PORT_FIVE_ADDRESS, tw);
            chk(16'({txs, empty}), 16'h0001);
            if (rows[i].wide) begin
                host.xfer(1'b0, 1'b0, 16'h0000, q);
                chk(q, tw);
            end else begin
                host.xfer(1'b0, 1'b1, 16'h0000, q);
                chk({8'h00, q[7:0]}, {8'h00, tw[15:8]});
                chk(16'({txs, empty}), 16'h0001);
                host.xfer(1'b0, 1'b0, 16'h0000, q);
                chk({8'h00, q[7:0]}, {8'h00, tw[7:0]});
            end
            chk(16'({txs, empty}), 16'h0002);
        end
        // clear attempted too soon after the read must be ignored
        @(posedge clk_sys_i);
        pws <= 1'b1;
        host.xfer(1'b1, 1'b0, 16'h0F0F, q);
        core(1'b1, 1'b0, PORT_FIVE_ADDRESS, 16'h0000);
        chk(rdata, 16'h0F0F);
        core(1'b0, 1'b1, PORT_ZERO_ADDRESS, 16'h0001);
        chk(16'(flag), 16'h0001);
        repeat (4) @(posedge clk_sys_i);
        core(1'b0, 1'b1, PORT_ZERO_ADDRESS, 16'h0001);
        chk(16'(flag), 16'h0000);
        // mid-run reset returns every status and flag to idle
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk(16'({rxs, txs, irq, flag, empty, oe}), 16'h0002);
        // both mode pins high: general ports, host read strobe ignored
        @(posedge clk_sys_i);
        pm <= 1'b1;
        mc <= 1'b1;
        core(1'b0, 1'b1, 3'h3, 16'hBEEF);
        chk(16'({gpw, cmode, 1'b0, gpa}), 16'h0023);
        chk(gpd, 16'hBEEF);
        host.xfer(1'b0, 1'b0, 16'h0000, q);
        chk(q, 16'h0000);
        print_verdict();
    end
endmodule
